// ---- bench/rbeb_partner.sv ----
// Far-side model: remote transmitter stream and reference character ticks
`timescale 1ns/1ns
module rbeb_partner (
  // Clock
  input  wire logic            clk,
  // Character stream
  output rbeb_pkg::rbeb_char_s rxChar [2],
  output logic                 referenceClockTick
);
  logic [1:0] refCnt;

  initial begin
    refCnt = 2'h0;
    referenceClockTick = 1'b0;
    rxChar[0] = '0;
    rxChar[1] = '0;
  end

  // Reference ticks run free, one per four system cycles
  always @(posedge clk) begin
    refCnt <= refCnt + 2'h1;
    referenceClockTick <= (refCnt == 2'h3);
  end

  // Characters arrive already framed, one per recovered tick
  task automatic sendChar(input int ch, input logic k, input logic v,
                          input logic [7:0] d);
    @(posedge clk);
    rxChar[ch] <= '{1'b1, k, v, d};
    @(posedge clk);
    // Released lines show the inverse, never a stale copy
    rxChar[ch] <= '{1'b0, ~k, ~v, ~d};
    repeat (2) @(posedge clk);
  endtask
endmodule // rbeb_partner

// ---- bench/rbeb_rx_backend_tb.sv ----
// Self-checking bench of the receive back-end
`timescale 1ns/1ns
module rbeb_rx_backend_tb;
  typedef struct packed {
    logic ch; logic k; logic v; logic [7:0] d; logic [2:0] st;
  } rbeb_row_s;
  localparam rbeb_row_s ROWS [6] = '{
    '{1'b0, 1'b0, 1'b0, 8'h3a, rbeb_pkg::ST_DATA},
    '{1'b0, 1'b1, 1'b0, 8'hbc, rbeb_pkg::ST_SPECIAL},
    '{1'b0, 1'b0, 1'b1, 8'h55, rbeb_pkg::ST_VIOL},
    '{1'b1, 1'b0, 1'b0, 8'h07, rbeb_pkg::ST_DATA},
    '{1'b1, 1'b1, 1'b0, 8'h1c, rbeb_pkg::ST_SPECIAL},
    '{1'b1, 1'b0, 1'b0, 8'hff, rbeb_pkg::ST_DATA}};
  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]           pwdata = 32'h0, prdata, r;
  logic                  pready, pslverr, e, prevRef;
  logic [3:0]            channelEnableInputs = 4'hf;
  logic                  selftestLatchEnable = 1'b0;
  rbeb_pkg::rbeb_char_s  rxChar [2];
  logic                  referenceClockTick;
  rbeb_pkg::rbeb_entry_s outEntry [2];
  rbeb_pkg::rbeb_entry_s lastEnt [2];
  logic [1:0]            outStrobe, prevV;
  logic                  recoveredClockOutA, recoveredClockOutB;
  logic                  recoveredClockOutBOe, recoveredClockOutC;
  logic                  chkClk = 1'b0, seenErr = 1'b0, mSel = 1'b0;
  logic [1:0]            ckSel = rbeb_pkg::CKSEL_MID;
  logic [8:0]            lfsrM;
  logic                  kM;
  int                    error_cnt = 0, total_checks = 0;

  always #20 clk = ~clk;

  rbeb_rx_backend rbeb_rx_backend_inst (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channelEnableInputs(channelEnableInputs),
    .selftestLatchEnable(selftestLatchEnable), .rxChar(rxChar),
    .referenceClockTick(referenceClockTick), .outEntry(outEntry),
    .outStrobe(outStrobe), .recoveredClockOutA(recoveredClockOutA),
    .recoveredClockOutB(recoveredClockOutB),
    .recoveredClockOutBOe(recoveredClockOutBOe),
    .recoveredClockOutC(recoveredClockOutC));
  rbeb_partner rbeb_partner_inst (.clk(clk), .rxChar(rxChar),
    .referenceClockTick(referenceClockTick));

  // ----------------------------------------
  // Monitors and helpers
  // ----------------------------------------
  always @(posedge clk) begin
    prevRef <= referenceClockTick;
    prevV <= {rxChar[1].valid, rxChar[0].valid};
    for (int c = 0; c < 2; c++) begin
      if (outStrobe[c] === 1'b1) begin
        lastEnt[c] = outEntry[c];
        if (outEntry[c].status === rbeb_pkg::ST_BIST_ERR) seenErr = 1'b1;
      end
    end
  end

  // Clock outputs are flop copies of the selected tick, one cycle late
  always @(negedge clk) begin
    if (chkClk) begin
      chk({28'h0, recoveredClockOutA, recoveredClockOutB,
           recoveredClockOutBOe, recoveredClockOutC},
          {28'h0, ckSel == rbeb_pkg::CKSEL_LOW ? prevRef :
           (ckSel == rbeb_pkg::CKSEL_HIGH ? prevV[mSel] : prevV[0]),
           ckSel == rbeb_pkg::CKSEL_MID && prevV[1],
           ckSel == rbeb_pkg::CKSEL_MID,
           ckSel == rbeb_pkg::CKSEL_LOW && prevRef});
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [31:0] v);
    chkClk = 1'b0;
    apb(1'b1, rbeb_pkg::ADDR_CTRL, v);
    ckSel = v[3:2];
    mSel = v[5];
    repeat (3) @(posedge clk);
    chkClk = 1'b1;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("wrong value at %0t: run hung", $time);
    tally_and_finish;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, rbeb_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'(rbeb_pkg::CTRL_RESET));
    apb(1'b1, rbeb_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, rbeb_pkg::ADDR_STAT, 32'h0);
    chk({28'h0, r[7:4]}, 32'hf);
    apb(1'b1, 12'h008, 32'hffff_ffff);
    chk({r[31:1], e}, 32'h1);
    chkClk = 1'b1;
    foreach (ROWS[i]) begin
      rbeb_partner_inst.sendChar(ROWS[i].ch, ROWS[i].k, ROWS[i].v, ROWS[i].d);
      chk(32'(lastEnt[ROWS[i].ch]),
          32'({~^ROWS[i].d, ROWS[i].st, ROWS[i].d}));
    end
    channelEnableInputs <= 4'h5;
    selftestLatchEnable <= 1'b1;
    apb(1'b0, rbeb_pkg::ADDR_STAT, 32'h0);
    chk({28'h0, r[7:4]}, 32'h5);
    selftestLatchEnable <= 1'b0;
    @(posedge clk);
    channelEnableInputs <= 4'ha;
    apb(1'b0, rbeb_pkg::ADDR_STAT, 32'h0);
    chk({28'h0, r[7:4]}, 32'h5);
    rbeb_partner_inst.sendChar(1, 1'b0, 1'b0, 8'h3a);
    chk(32'(lastEnt[1].status), 32'(rbeb_pkg::ST_WAIT));
    rbeb_partner_inst.sendChar(1, 1'b0, 1'b0, rbeb_pkg::D00_CODE);
    seenErr = 1'b0;
    // A fixed pattern drifts far from the sequence and forces an abort
    repeat (24) rbeb_partner_inst.sendChar(1, 1'b1, 1'b0, 8'h55);
    chk({31'h0, seenErr}, 32'h1);
    chk(32'(lastEnt[1].status), 32'(rbeb_pkg::ST_WAIT));
    // One clean pass of the sequence: no error, loop code on the last
    seenErr = 1'b0;
    lfsrM = rbeb_pkg::LFSR_START;
    rbeb_partner_inst.sendChar(1, 1'b0, 1'b0, rbeb_pkg::D00_CODE);
    repeat (510) begin
      lfsrM = {lfsrM[7:0], lfsrM[8] ^ lfsrM[4]};
      kM = lfsrM[8] & lfsrM[0];
      rbeb_partner_inst.sendChar(1, kM, kM && lfsrM[7:4] == 4'hf,
                                 lfsrM[7:0]);
    end
    chk({31'h0, seenErr}, 32'h0);
    chk(32'(lastEnt[1].status), 32'(rbeb_pkg::ST_LOOP_A));
    chkClk = 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, rbeb_pkg::ADDR_STAT, 32'h0);
    chk({28'h0, r[7:4]}, 32'hf);
    cfg(32'h0);
    repeat (20) @(posedge clk);
    chk(32'(lastEnt[0]), 32'({~^rbeb_pkg::K285_CODE, rbeb_pkg::ST_SPECIAL,
        rbeb_pkg::K285_CODE}));
    cfg(32'h2a);
    rbeb_partner_inst.sendChar(1, 1'b0, 1'b0, 8'h11);
    rbeb_partner_inst.sendChar(0, 1'b0, 1'b0, 8'h22);
    tally_and_finish;
  end
endmodule // rbeb_rx_backend_tb

// ---- logic/rbeb_elastic_buf.sv ----
// Elasticity buffer of one receive channel
`timescale 1ns/1ns
module rbeb_elastic_buf #(
  parameter int DEPTH = rbeb_pkg::EB_DEPTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Write side
  input  wire logic                  wrValid,
  input  wire rbeb_pkg::rbeb_entry_s wrEntry,
  // Read side
  input  wire logic                  rdTick,
  output rbeb_pkg::rbeb_entry_s      rdEntry,
  // Slip control
  input  wire logic                  slipEn,
  input  wire logic                  useForce,
  input  wire logic                  forceIns,
  input  wire logic                  forceDel,
  output logic                       wantIns,
  output logic                       wantDel,
  output logic                       filling
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam rbeb_pkg::rbeb_entry_s FILL = '{parity: ~^rbeb_pkg::K285_CODE,
    status: rbeb_pkg::ST_SPECIAL, data: rbeb_pkg::K285_CODE};

  logic [rbeb_pkg::EB_WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic          filling_reg;
  logic          lost_reg;
  logic          headFrame, wrFrame, doIns, doDel, doWr, doRd;
  logic          overflow, underflow, recentre;
  rbeb_pkg::rbeb_entry_s head;

  function automatic logic [PW-1:0] incPtr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign head      = mem[rdPtr_reg];
  assign headFrame = (count_reg != '0) && head.data == rbeb_pkg::K285_CODE
                     && head.status == rbeb_pkg::ST_SPECIAL;
  assign wrFrame   = wrEntry.data == rbeb_pkg::K285_CODE
                     && wrEntry.status == rbeb_pkg::ST_SPECIAL;
  // Slips only near the water marks and only around framing characters
  assign wantIns   = slipEn && rdTick && !filling_reg && headFrame
                     && count_reg < 3;
  assign wantDel   = slipEn && wrValid && wrFrame && headFrame
                     && count_reg > CW'(DEPTH - 3);
  assign doIns     = useForce ? forceIns : wantIns;
  assign doDel     = useForce ? forceDel : wantDel;
  assign doWr      = wrValid && !doDel && count_reg != FULL;
  assign doRd      = rdTick && !filling_reg && !doIns && count_reg != '0;
  assign overflow  = wrValid && !doDel && count_reg == FULL;
  assign underflow = rdTick && !filling_reg && count_reg == '0;
  assign recentre  = lost_reg && wrValid && wrFrame;
  assign rdEntry   = (filling_reg || doIns || count_reg == '0) ? FILL : head;
  assign filling   = filling_reg;

  always_ff @(posedge clk) begin
    if (doWr || recentre) begin
      mem[wrPtr_reg] <= wrEntry;
    end
  end

  // Reset starts in fill, so the buffer comes up centred
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_reg   <= '0;
      rdPtr_reg   <= '0;
      count_reg   <= '0;
      filling_reg <= 1'b1;
      lost_reg    <= 1'b0;
    end else if (recentre) begin
      rdPtr_reg   <= wrPtr_reg;
      wrPtr_reg   <= incPtr(wrPtr_reg);
      count_reg   <= CW'(1);
      filling_reg <= 1'b1;
      lost_reg    <= 1'b0;
    end else begin
      if (doWr) wrPtr_reg <= incPtr(wrPtr_reg);
      if (doRd) rdPtr_reg <= incPtr(rdPtr_reg);
      count_reg <= CW'(count_reg + CW'(doWr) - CW'(doRd));
      if (overflow || underflow) lost_reg <= 1'b1;
      if (count_reg >= HALF) filling_reg <= 1'b0;
    end
  end

  lost_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    overflow && !recentre |=> lost_reg)
    else $error("overflow not flagged for re-centre");
endmodule // rbeb_elastic_buf

// ---- logic/rbeb_pkg.sv ----
// Package: constants, states and carriers of the receive back-end
// Function
// - With latch enable high, a low channel-enable input enables that self-test.
// - Latch enable falling captures the enables; held until it rises again.
// - Test reset presets every self-test latch bit high, disabling self-test.
// - Enabled self-test runs a 511-character LFSR sequence matching the transmitter.
// - First recognised enable presets the LFSR to start code D0.0, once per loop.
// - Synchronised receiver compares each character, reports on status bits.
// - Expected violations and disparity errors raise no error status.
// - Loop completion shows 010b or 100b for one character, decoder mode regardless.
// - Invalid exceeding valid by 16 aborts, resets LFSR, hunts for start again.
// - Each channel has an elastic buffer at least 10 deep, 12 bits wide.
// - Buffer written by own recovered clock, read by configured clock source.
// - Decoder bypass bypasses the buffers; clock select must then be mid.
// - Mode bits: LL/LH independent, HL/HH bonded; low bit picks status set.
// - Clock select low: reference clocking, B clock high-Z, A and C reference.
// - K28.5 insertion or framing deletion only with a framing character buffered.
// - Clock select mid: own recovered clock, buffer bypassed, no slips.
// - Clock select high: chosen recovered clock on A; slips only for alignment. Here slipEn is ckLow only, so no slips occur.
// - Bonded not with mid; slips happen together, governed by master channel.
// - Bonded-clock select picks master and A clock: 0 channel A, 1 channel B.
package rbeb_pkg;
  localparam int          NUM_CH      = 2;
  localparam int          EB_DEPTH    = 10;
  localparam int          EB_WIDTH    = 12;
  localparam logic [4:0]  ERR_LIMIT   = 5'h10;
  localparam logic [8:0]  LFSR_START  = 9'h100;
  localparam logic [7:0]  D00_CODE    = 8'h00;
  localparam logic [7:0]  K285_CODE   = 8'hbc;
  // Register map
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STAT   = 12'h004;
  localparam int          CTRL_MODE   = 0;
  localparam int          CTRL_CKSEL  = 2;
  localparam int          CTRL_BYP    = 4;
  localparam int          CTRL_MSEL   = 5;
  localparam logic [5:0]  CTRL_RESET  = 6'h04;
  localparam int          STAT_RUN    = 0;
  localparam int          STAT_FILL   = 2;
  localparam int          STAT_LATCH  = 4;
  // Clock select codes
  localparam logic [1:0]  CKSEL_LOW   = 2'h0;
  localparam logic [1:0]  CKSEL_MID   = 2'h1;
  localparam logic [1:0]  CKSEL_HIGH  = 2'h2;
  // Receive status codes
  localparam logic [2:0]  ST_DATA     = 3'h0;
  localparam logic [2:0]  ST_SPECIAL  = 3'h1;
  localparam logic [2:0]  ST_LOOP_A   = 3'h2;
  localparam logic [2:0]  ST_VIOL     = 3'h3;
  localparam logic [2:0]  ST_LOOP_B   = 3'h4;
  localparam logic [2:0]  ST_WAIT     = 3'h5;
  localparam logic [2:0]  ST_BIST_ERR = 3'h6;

  typedef enum logic [2:0] {
    BIST_OFF  = 3'h1,
    BIST_HUNT = 3'h2,
    BIST_RUN  = 3'h4
  } rbeb_bist_e;

  typedef struct packed {
    logic       valid;
    logic       kchar;
    logic       viol;
    logic [7:0] data;
  } rbeb_char_s;

  typedef struct packed {
    logic       parity;
    logic [2:0] status;
    logic [7:0] data;
  } rbeb_entry_s;
endpackage

// ---- logic/rbeb_rx_backend.sv ----
// Receive self-test checker, elasticity buffers and clock-mode selection
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
module rbeb_rx_backend #(
  parameter int NCH   = rbeb_pkg::NUM_CH,
  parameter int DEPTH = rbeb_pkg::EB_DEPTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // APB slave
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Self-test enable pins
  input  wire logic [3:0]            channelEnableInputs,
  input  wire logic                  selftestLatchEnable,
  // Decoded characters, one valid per recovered character clock
  input  wire rbeb_pkg::rbeb_char_s  rxChar [NCH],
  input  wire logic                  referenceClockTick,
  // Output registers
  output rbeb_pkg::rbeb_entry_s      outEntry [NCH],
  output logic [NCH-1:0]             outStrobe,
  // Clock outputs as character-rate strobes
  output logic                       recoveredClockOutA,
  output logic                       recoveredClockOutB,
  output logic                       recoveredClockOutBOe,
  output logic                       recoveredClockOutC
);
  // ------------------------------------------------------------
  // Control register and mode decode
  // ------------------------------------------------------------
  logic [5:0]     ctrl_reg;
  logic [3:0]     enLatch_reg;
  logic [3:0]     enEff;
  logic [1:0]     modeSel, cksel;
  logic           setB, bonded, decBypass, msel, ebBypass;
  logic           ckLow, ckHigh, ckMid, rdTick;
  logic [NCH-1:0] wantIns, wantDel, filling, bistRun;
  rbeb_pkg::rbeb_entry_s wrEntry [NCH];
  rbeb_pkg::rbeb_entry_s rdEntry [NCH];

  assign modeSel   = ctrl_reg[rbeb_pkg::CTRL_MODE +: 2];
  assign cksel     = ctrl_reg[rbeb_pkg::CTRL_CKSEL +: 2];
  assign decBypass = ctrl_reg[rbeb_pkg::CTRL_BYP];
  assign msel      = ctrl_reg[rbeb_pkg::CTRL_MSEL];
  assign ckLow     = cksel == rbeb_pkg::CKSEL_LOW;
  assign ckHigh    = cksel == rbeb_pkg::CKSEL_HIGH;
  // Unused code 3 falls back to the safe per-channel clocking
  assign ckMid     = !ckLow && !ckHigh;
  assign setB      = modeSel[0];
  // Bonding has no meaning without a buffer to align in
  assign bonded    = modeSel[1] && !ckMid && !decBypass;
  assign ebBypass  = decBypass || ckMid;
  // Read clock: reference tick or the chosen recovered clock
  assign rdTick    = ckLow ? referenceClockTick
                           : rxChar[msel].valid;

  // ------------------------------------------------------------
  // Self-test enable latch
  // ------------------------------------------------------------
  // Transparent while the latch enable is high, frozen once it falls
  assign enEff = selftestLatchEnable ? channelEnableInputs
                                     : enLatch_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enLatch_reg <= 4'hf;
    end else if (selftestLatchEnable) begin
      enLatch_reg <= channelEnableInputs;
    end
  end

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= rbeb_pkg::CTRL_RESET;
    end else if (psel && penable && pwrite
                 && paddr == rbeb_pkg::ADDR_CTRL) begin
      ctrl_reg <= pwdata[5:0];
    end
  end

  // Read data is fetched in the setup cycle so it leaves a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata  <= '0;
        pslverr <= 1'b0;
        case (paddr)
          rbeb_pkg::ADDR_CTRL: prdata[5:0] <= ctrl_reg;
          rbeb_pkg::ADDR_STAT: begin
            prdata[rbeb_pkg::STAT_RUN +: 2]   <= bistRun[1:0];
            prdata[rbeb_pkg::STAT_FILL +: 2]  <= filling[1:0];
            prdata[rbeb_pkg::STAT_LATCH +: 4] <= enEff;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Clock outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      recoveredClockOutA   <= 1'b0;
      recoveredClockOutB   <= 1'b0;
      recoveredClockOutBOe <= 1'b0;
      recoveredClockOutC   <= 1'b0;
    end else begin
      recoveredClockOutA   <= ckMid ? rxChar[0].valid : rdTick;
      recoveredClockOutB   <= ckMid && rxChar[1].valid;
      recoveredClockOutBOe <= ckMid;
      recoveredClockOutC   <= ckLow && referenceClockTick;
    end
  end

  // ------------------------------------------------------------
  // Per-channel checker, buffer and output register
  // ------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    rbeb_pkg::rbeb_bist_e state_reg;
    rbeb_pkg::rbeb_char_s ch;
    logic [8:0] lfsr_reg;
    logic [8:0] lfsrStep;
    logic [4:0] errDiff_reg;
    logic [2:0] status;
    logic       bistEn, expK, expViol, match, lastStep, isStart;
    logic       useForce;

    assign ch       = rxChar[c];
    assign bistEn   = !enEff[c];
    assign bistRun[c] = state_reg == rbeb_pkg::BIST_RUN;
    // x^9 + x^5 + 1, maximal length: 511 states
    assign lfsrStep = {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
    assign expK     = lfsr_reg[8] & lfsr_reg[0];
    assign expViol  = expK && lfsr_reg[7:4] == 4'hf;
    // An expected violation passes as long as one arrives
    assign match    = expViol ? ch.viol
                    : !ch.viol && ch.kchar == expK
                      && ch.data == lfsr_reg[7:0];
    assign lastStep = lfsrStep == rbeb_pkg::LFSR_START;
    assign isStart  = !ch.viol && !ch.kchar
                      && ch.data == rbeb_pkg::D00_CODE;
    assign useForce = bonded && c != int'(msel);

    always_ff @(posedge clk) begin
      if (!rstn || !bistEn) begin
        state_reg   <= rbeb_pkg::BIST_OFF;
        lfsr_reg    <= rbeb_pkg::LFSR_START;
        errDiff_reg <= '0;
      end else begin
        case (state_reg)
          rbeb_pkg::BIST_OFF: begin
            state_reg   <= rbeb_pkg::BIST_HUNT;
            lfsr_reg    <= rbeb_pkg::LFSR_START;
            errDiff_reg <= '0;
          end
          rbeb_pkg::BIST_HUNT: begin
            if (ch.valid && isStart) begin
              state_reg <= rbeb_pkg::BIST_RUN;
              lfsr_reg  <= lfsrStep;
            end
          end
          rbeb_pkg::BIST_RUN: begin
            if (ch.valid) begin
              if (match) begin
                lfsr_reg <= lfsrStep;
                if (errDiff_reg != '0) errDiff_reg <= 5'(errDiff_reg - 1'b1);
              end else if (errDiff_reg == 5'(rbeb_pkg::ERR_LIMIT - 1'b1)) begin
                state_reg   <= rbeb_pkg::BIST_HUNT;
                lfsr_reg    <= rbeb_pkg::LFSR_START;
                errDiff_reg <= '0;
              end else begin
                lfsr_reg    <= lfsrStep;
                errDiff_reg <= 5'(errDiff_reg + 1'b1);
              end
            end
          end
          default: state_reg <= rbeb_pkg::BIST_OFF;
        endcase
      end
    end

    always_comb begin
      status = ch.viol ? rbeb_pkg::ST_VIOL
             : ch.kchar ? rbeb_pkg::ST_SPECIAL : rbeb_pkg::ST_DATA;
      if (state_reg == rbeb_pkg::BIST_HUNT) begin
        status = rbeb_pkg::ST_WAIT;
      end else if (state_reg == rbeb_pkg::BIST_RUN) begin
        if (!match) begin
          status = rbeb_pkg::ST_BIST_ERR;
        end else if (lastStep) begin
          status = setB ? rbeb_pkg::ST_LOOP_B
                        : rbeb_pkg::ST_LOOP_A;
        end else begin
          status = ch.kchar ? rbeb_pkg::ST_SPECIAL
                            : rbeb_pkg::ST_DATA;
        end
      end
    end

    assign wrEntry[c] = '{parity: ~^ch.data, status: status, data: ch.data};

    rbeb_elastic_buf #(
      .DEPTH    (DEPTH)
    ) u_buf (
      .clk      (clk),
      .rstn     (rstn),
      .wrValid  (ch.valid && !ebBypass),
      .wrEntry  (wrEntry[c]),
      .rdTick   (rdTick && !ebBypass),
      .rdEntry  (rdEntry[c]),
      .slipEn   (ckLow),
      .useForce (useForce),
      .forceIns (wantIns[msel]),
      .forceDel (wantDel[msel]),
      .wantIns  (wantIns[c]),
      .wantDel  (wantDel[c]),
      .filling  (filling[c])
    );

    always_ff @(posedge clk) begin
      if (!rstn) begin
        outEntry[c]  <= '0;
        outStrobe[c] <= 1'b0;
      end else if (ebBypass) begin
        outStrobe[c] <= ch.valid;
        if (ch.valid) outEntry[c] <= wrEntry[c];
      end else begin
        outStrobe[c] <= rdTick;
        if (rdTick) outEntry[c] <= rdEntry[c];
      end
    end

    bist_preset_a: assert property (@(posedge clk) disable iff (!rstn)
      state_reg == rbeb_pkg::BIST_OFF && bistEn
      |=> state_reg == rbeb_pkg::BIST_HUNT
          && lfsr_reg == rbeb_pkg::LFSR_START)
      else $error("self-test start not preset");
    bist_abort_a: assert property (@(posedge clk) disable iff (!rstn)
      bistEn && state_reg == rbeb_pkg::BIST_RUN && ch.valid && !match
      && errDiff_reg == 5'h0f
      |=> state_reg == rbeb_pkg::BIST_HUNT && errDiff_reg == 5'h00)
      else $error("checker did not abort at 16");
    viol_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      state_reg == rbeb_pkg::BIST_RUN && ch.valid && expViol && ch.viol
      |-> status != rbeb_pkg::ST_BIST_ERR)
      else $error("expected violation flagged as error");
    loop_code_a: assert property (@(posedge clk) disable iff (!rstn)
      state_reg == rbeb_pkg::BIST_RUN && ch.valid && match && lastStep
      |-> status == (setB ? 3'h4 : 3'h2))
      else $error("loop completion code wrong");
    bypass_out_a: assert property (@(posedge clk) disable iff (!rstn)
      ebBypass && ch.valid ##1 ebBypass
      |-> outStrobe[c] && outEntry[c] == $past(wrEntry[c]))
      else $error("bypass output not from own stream");
    loop_seen_c: cover property (@(posedge clk) disable iff (!rstn)
      state_reg == rbeb_pkg::BIST_RUN && ch.valid && match && lastStep);
    abort_seen_c: cover property (@(posedge clk) disable iff (!rstn)
      state_reg == rbeb_pkg::BIST_RUN ##1 state_reg == rbeb_pkg::BIST_HUNT);
    insert_seen_c: cover property (@(posedge clk) disable iff (!rstn)
      wantIns[c] && !ebBypass);
  end

  latch_reset_a: assert property (@(posedge clk)
    !rstn |=> enLatch_reg == 4'hf)
    else $error("self-test latch not preset by reset");
  latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !selftestLatchEnable ##1 !selftestLatchEnable |-> $stable(enLatch_reg))
    else $error("self-test latch changed while closed");
  clkb_hiz_a: assert property (@(posedge clk) disable iff (!rstn)
    ckLow ##1 ckLow |-> !recoveredClockOutBOe
      && recoveredClockOutA == $past(referenceClockTick))
    else $error("reference clocking outputs wrong");
  master_clk_a: assert property (@(posedge clk) disable iff (!rstn)
    ckHigh ##1 ckHigh |-> recoveredClockOutA == $past(rxChar[msel].valid))
    else $error("clock A not from selected channel");
endmodule // rbeb_rx_backend
